// ---- src/thermal_pkg.sv ----
package thermal_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int CONV_BASE_MS = 125;
  localparam int CONV_BASE_CYCLES = CLK_HZ / 1000 * CONV_BASE_MS;
  localparam logic [2:0] RATE_CODE_MAX = 3'h7;

  // ----------------------------------------------------------------
  // Register pointer values
  // ----------------------------------------------------------------
  localparam logic [7:0] RD_LOCAL = 8'h00;
  localparam logic [7:0] RD_REMOTE = 8'h01;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_CTRL = 8'h03;
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] RD_LHI = 8'h05;
  localparam logic [7:0] RD_LLO = 8'h06;
  localparam logic [7:0] RD_RHI = 8'h07;
  localparam logic [7:0] RD_RLO = 8'h08;
  localparam logic [7:0] WR_CTRL = 8'h09;
  localparam logic [7:0] WR_RATE = 8'h0A;
  localparam logic [7:0] WR_LHI = 8'h0B;
  localparam logic [7:0] WR_LLO = 8'h0C;
  localparam logic [7:0] WR_RHI = 8'h0D;
  localparam logic [7:0] WR_RLO = 8'h0E;
  localparam logic [7:0] WR_SHOT = 8'h0F;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_VALUE = 8'h80;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h02;
  localparam logic [7:0] RST_HI = 8'h7F;
  localparam logic [7:0] RST_LO = 8'hC9;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] CTRL_USED = 8'hC0;
  localparam int CTRL_MASK_BIT = 7;
  localparam int CTRL_SLEEP_PIN_N_BIT = 6;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

  // ----------------------------------------------------------------
  // Address straps
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [3:0] ADDR_HI_LOW = 4'h3;
  localparam logic [3:0] ADDR_HI_OPEN = 4'h5;
  localparam logic [3:0] ADDR_HI_HIGH = 4'h9;
  localparam logic [2:0] ADDR_LO_BASE_LOW = 3'h0;
  localparam logic [2:0] ADDR_LO_BASE_OPEN = 3'h1;
  localparam logic [2:0] ADDR_LO_BASE_HIGH = 3'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
    logic sensor_open;
  } meas_s;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_WR, S_ACK_WR, S_RD, S_RD_ACK, S_IGNORE
  } serial_state_e;
endpackage : thermal_pkg

// ---- src/addr_strap.sv ----
`timescale 1ns/1ns
module addr_strap (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [1:0] i_strap_first,
  input wire logic [1:0] i_strap_second,
  output logic [6:0] o_own_addr,
  output logic o_valid
);
  import thermal_pkg::*;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } strap_state_s;

  strap_state_s st;
  strap_state_s nx;

  // Straps are read once, on the first edge after reset release, never again.
  always_comb begin
    nx = st;
    if (!st.valid) begin
      nx.valid = 1'b1;
      case (i_strap_first)
        STRAP_LOW: nx.addr = {ADDR_HI_LOW, ADDR_LO_BASE_LOW + {1'b0, i_strap_second}};
        STRAP_HIGH: nx.addr = {ADDR_HI_HIGH, ADDR_LO_BASE_HIGH + {1'b0, i_strap_second}};
        default: nx.addr = {ADDR_HI_OPEN, ADDR_LO_BASE_OPEN + {1'b0, i_strap_second}};
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign o_own_addr = st.addr;
  assign o_valid = st.valid;

  property p_addr_frozen;
    @(posedge i_clk) disable iff (i_srst) st.valid |=> $stable(o_own_addr);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("Own address changed after capture.");

  property p_addr_high_nibble;
    @(posedge i_clk) disable iff (i_srst)
      $rose(o_valid) && $past(i_strap_first) == STRAP_HIGH |-> o_own_addr[6:3] == ADDR_HI_HIGH;
  endproperty
  a_addr_high_nibble: assert property (p_addr_high_nibble) else $error("Wrong nibble for high strap.");
endmodule : addr_strap

// ---- src/conv_timer.sv ----
`timescale 1ns/1ns
module conv_timer #(
  parameter int BASE_CYCLES = thermal_pkg::CONV_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic [2:0] i_rate,
  output logic o_tick
);
  import thermal_pkg::*;

  typedef struct packed {
    logic [31:0] base;
    logic [7:0] div;
    logic tick;
  } timer_state_s;

  timer_state_s st;
  timer_state_s nx;
  logic [7:0] periods;

  // Code 7 gives one base period, each lower code doubles it.
  assign periods = 8'h01 << (RATE_CODE_MAX - i_rate);

  // Counting stops in standby, so the next conversion waits a full period.
  always_comb begin
    nx = st;
    nx.tick = 1'b0;
    if (!i_run) begin
      nx.base = '0;
      nx.div = '0;
    end else if (st.base == 32'(BASE_CYCLES - 1)) begin
      nx.base = '0;
      if (st.div >= periods - 8'h01) begin
        nx.div = '0;
        nx.tick = 1'b1;
      end else begin
        nx.div = st.div + 8'h01;
      end
    end else begin
      nx.base = st.base + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign o_tick = st.tick;
endmodule : conv_timer

// ---- src/thermal_monitor_serial_regs.sv ----
`timescale 1ns/1ns
// How it works
// - Write to pointer 0F starts one measurement in soft standby.
// - Status read never releases the alarm latch.
// - Control bit 6 set stops conversions.
// - Low sleep pin also forces standby.
// - Standby freezes both temperature value registers except for a one-shot result.
// - Control bit 7 masks alarm; bits 5-0 reserved.
// - Rate code divides period, 16 s to 125 ms.
// - Limits readable, writable; strict greater/less compares.
// - One-shot in soft standby converts once, returns.
// - Two three-level straps select slave address.
// - Straps captured once after every reset release.
// - Start, 7-bit address MSB first, direction bit.
// - Matching address acknowledged on ninth clock.
// - Nine clocks per byte; data moves while low.
// - Writes carry one or two bytes; reads one.
// - First write byte loads pointer, second stores.
// - Reads use the retained pointer.
// - Read 00-08 and write 09-0E register map.
// - Flags set latch; status read clears cleared faults.
// - Alert response read returns own address, releases only with no flags set.
module thermal_monitor_serial_regs #(
  parameter int BASE_CYCLES = thermal_pkg::CONV_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_serial_data_line,
  output logic o_serial_data_line,
  output logic o_serial_data_line_oe,
  input wire logic i_sleep_pin_n,
  input wire logic [1:0] i_addr_strap_first,
  input wire logic [1:0] i_addr_strap_second,
  output logic o_alarm_n,
  output logic o_alarm_n_oe,
  output logic o_conv_start,
  input wire logic i_conv_done,
  input wire thermal_pkg::meas_s i_meas
);
  import thermal_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    serial_state_e state;
    logic scl;
    logic sda;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] idx;
    logic ara;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] ctrl;
    logic [7:0] rate;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic [7:0] lval;
    logic [7:0] rval;
    logic sensor_open;
    logic [4:0] flags;
    logic latch;
    logic busy;
    logic oneshot;
    logic conv_start;
    logic alarm_oe;
  } mon_state_s;

  mon_state_s st;
  mon_state_s nx;
  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic standby;
  logic tick;
  logic [6:0] own_addr;
  logic own_valid;
  logic addr_hit;
  logic own_hit;
  logic ara_hit;
  logic shot_hit;
  logic stat_clear;
  logic ara_release;
  logic [4:0] cond;
  logic [7:0] rx_byte;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  addr_strap u_strap (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_strap_first(i_addr_strap_first),
    .i_strap_second(i_addr_strap_second),
    .o_own_addr(own_addr),
    .o_valid(own_valid)
  );

  conv_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(!standby),
    .i_rate(st.rate[2:0]),
    .o_tick(tick)
  );

  // Bus edges are judged against the previous sample, so a glitch shorter
  // than one clock is seen only if it lands on an edge.
  assign rise = i_scl && !st.scl;
  assign fall = !i_scl && st.scl;
  assign start_cond = i_scl && st.scl && st.sda && !i_serial_data_line;
  assign stop_cond = i_scl && st.scl && !st.sda && i_serial_data_line;
  assign standby = st.ctrl[CTRL_SLEEP_PIN_N_BIT] || !i_sleep_pin_n;
  assign rx_byte = {st.sh[6:0], i_serial_data_line};
  assign own_hit = own_valid && st.sh[7:1] == own_addr;
  assign ara_hit = st.sh[7:1] == ALERT_RESP_ADDR && st.sh[0] && st.latch;
  assign addr_hit = own_hit || ara_hit;

  // Live limit comparisons on the stored values, signed.
  assign cond[4] = $signed(st.lval) > $signed(st.lhi);
  assign cond[3] = $signed(st.lval) < $signed(st.llo);
  assign cond[2] = $signed(st.rval) > $signed(st.rhi);
  assign cond[1] = $signed(st.rval) < $signed(st.rlo);
  assign cond[0] = st.sensor_open;

  // Register read multiplexer; write addresses and holes read as zero.
  function automatic logic [7:0] reg_read(input mon_state_s s);
    case (s.ptr)
      RD_LOCAL: reg_read = s.lval;
      RD_REMOTE: reg_read = s.rval;
      RD_STATUS: reg_read = {s.busy, s.flags[4:1], s.flags[0], 2'b00};
      RD_CTRL: reg_read = s.ctrl;
      RD_RATE: reg_read = s.rate;
      RD_LHI: reg_read = s.lhi;
      RD_LLO: reg_read = s.llo;
      RD_RHI: reg_read = s.rhi;
      RD_RLO: reg_read = s.rlo;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Serial slave, registers and conversion control
  // ----------------------------------------------------------------
  always_comb begin
    nx = st;
    nx.scl = i_scl;
    nx.sda = i_serial_data_line;
    nx.conv_start = 1'b0;
    shot_hit = 1'b0;
    stat_clear = 1'b0;
    ara_release = 1'b0;
    if (start_cond) begin
      nx.state = S_ADDR;
      nx.cnt = '0;
      nx.idx = '0;
      nx.sda_oe = 1'b0;
    end else if (stop_cond) begin
      nx.state = S_IDLE;
      nx.sda_oe = 1'b0;
    end else begin
      case (st.state)
        S_ADDR: begin
          if (rise) begin
            nx.sh = rx_byte;
            nx.cnt = st.cnt + 4'h1;
          end else if (fall && st.cnt == 4'h8) begin
            nx.ara = ara_hit && !own_hit;
            nx.sda_oe = addr_hit;
            nx.state = addr_hit ? S_ACK_ADDR : S_IGNORE;
          end
        end
        S_ACK_ADDR: begin
          if (fall) begin
            nx.cnt = 4'h1;
            if (st.sh[0]) begin
              // Read data is taken at this edge; the first bit goes out now.
              nx.sh = st.ara ? {own_addr, 1'b0} : reg_read(st);
              nx.sda_oe = !nx.sh[7];
              nx.state = S_RD;
              stat_clear = !st.ara && st.ptr == RD_STATUS;
              ara_release = st.ara;
            end else begin
              nx.cnt = '0;
              nx.sda_oe = 1'b0;
              nx.state = S_WR;
            end
          end
        end
        S_WR: begin
          if (rise) begin
            nx.sh = rx_byte;
            nx.cnt = st.cnt + 4'h1;
          end else if (fall && st.cnt == 4'h8) begin
            nx.sda_oe = 1'b1;
            nx.state = S_ACK_WR;
            if (st.idx == 2'h0) begin
              nx.ptr = st.sh;
              shot_hit = st.sh == WR_SHOT;
            end else if (st.idx == 2'h1) begin
              case (st.ptr)
                WR_CTRL: nx.ctrl = st.sh & CTRL_USED;
                WR_RATE: nx.rate = st.sh;
                WR_LHI: nx.lhi = st.sh;
                WR_LLO: nx.llo = st.sh;
                WR_RHI: nx.rhi = st.sh;
                WR_RLO: nx.rlo = st.sh;
                default: nx.rate = st.rate;
              endcase
            end
          end
        end
        S_ACK_WR: begin
          if (fall) begin
            nx.sda_oe = 1'b0;
            nx.cnt = '0;
            nx.idx = (st.idx == 2'h2) ? st.idx : st.idx + 2'h1;
            nx.state = S_WR;
          end
        end
        S_RD: begin
          if (fall) begin
            if (st.cnt == 4'h8) begin
              nx.sda_oe = 1'b0;
              nx.state = S_RD_ACK;
            end else begin
              nx.sh = {st.sh[6:0], 1'b0};
              nx.sda_oe = !st.sh[6];
              nx.cnt = st.cnt + 4'h1;
            end
          end
        end
        S_RD_ACK: begin
          // One byte per read; whatever the master answers, step aside.
          if (rise) begin
            nx.state = S_IGNORE;
          end
        end
        S_IGNORE: nx.sda_oe = 1'b0;
        S_IDLE: nx.sda_oe = 1'b0;
        default: begin
          nx.state = S_IDLE;
          nx.sda_oe = 1'b0;
        end
      endcase
    end

    // A fault present in this cycle always wins over a clear.
    nx.flags = (stat_clear ? st.flags & cond : st.flags) | cond;
    nx.latch = (ara_release ? 1'b0 : st.latch) | (|st.flags);
    nx.alarm_oe = nx.latch && !nx.ctrl[CTRL_MASK_BIT];

    // Conversion scheduling. Standby aborts a running free conversion.
    if (st.busy && standby && !st.oneshot) begin
      nx.busy = 1'b0;
    end else if (st.busy && i_conv_done) begin
      nx.busy = 1'b0;
      nx.oneshot = 1'b0;
      nx.lval = i_meas.local_temp;
      nx.rval = i_meas.remote_temp;
      nx.sensor_open = i_meas.sensor_open;
    end else if (!st.busy && tick && !standby) begin
      nx.busy = 1'b1;
      nx.conv_start = 1'b1;
    end else if (!st.busy && shot_hit && st.ctrl[CTRL_SLEEP_PIN_N_BIT] && i_sleep_pin_n) begin
      nx.busy = 1'b1;
      nx.oneshot = 1'b1;
      nx.conv_start = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= '0;
      st.state <= S_IDLE;
      st.scl <= 1'b1;
      st.sda <= 1'b1;
      st.ptr <= RST_PTR;
      st.ctrl <= RST_CTRL;
      st.rate <= RST_RATE;
      st.lhi <= RST_HI;
      st.llo <= RST_LO;
      st.rhi <= RST_HI;
      st.rlo <= RST_LO;
      st.lval <= RST_VALUE;
      st.rval <= RST_VALUE;
    end else begin
      st <= nx;
    end
  end

  // The data and alarm pins only ever pull low.
  assign o_serial_data_line = 1'b0;
  assign o_serial_data_line_oe = st.sda_oe;
  assign o_alarm_n = 1'b0;
  assign o_alarm_n_oe = st.alarm_oe;
  assign o_conv_start = st.conv_start;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_addr_hit;
    st.state == S_ADDR && !start_cond && !stop_cond && fall && st.cnt == 4'h8 && addr_hit;
  endsequence

  sequence s_shot_soft;
    shot_hit && !st.busy && st.ctrl[CTRL_SLEEP_PIN_N_BIT] && i_sleep_pin_n && !start_cond && !stop_cond;
  endsequence

  property p_shot_start;
    s_shot_soft |=> o_conv_start && st.oneshot;
  endproperty
  a_shot_start: assert property (p_shot_start) else $error("One-shot write did not start a conversion.");

  property p_stat_keeps_latch;
    stat_clear && st.latch |=> st.latch;
  endproperty
  a_stat_keeps_latch: assert property (p_stat_keeps_latch) else $error("Status read released the alarm.");

  property p_soft_standby;
    st.ctrl[CTRL_SLEEP_PIN_N_BIT] && !shot_hit |=> !o_conv_start;
  endproperty
  a_soft_standby: assert property (p_soft_standby) else $error("Conversion started in standby.");

  property p_pin_standby;
    !i_sleep_pin_n |=> !o_conv_start;
  endproperty
  a_pin_standby: assert property (p_pin_standby) else $error("Conversion started with sleep pin low.");

  property p_values_frozen;
    standby && !st.busy ##1 standby && !st.busy |-> $stable(st.lval) && $stable(st.rval);
  endproperty
  a_values_frozen: assert property (p_values_frozen) else $error("Value changed in standby.");

  property p_mask;
    st.ctrl[CTRL_MASK_BIT] |-> !o_alarm_n_oe;
  endproperty
  a_mask: assert property (p_mask) else $error("Masked alarm still driven.");

  property p_high_limit;
    $signed(st.lval) > $signed(st.lhi) |=> st.flags[4] ##1 st.latch;
  endproperty
  a_high_limit: assert property (p_high_limit) else $error("High limit trip not flagged.");

  property p_addr_ack;
    s_addr_hit |=> o_serial_data_line_oe && st.state == S_ACK_ADDR;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged.");

  property p_release;
    st.state == S_IGNORE || st.state == S_IDLE |-> !o_serial_data_line_oe;
  endproperty
  a_release: assert property (p_release) else $error("Data line driven while idle.");

  property p_pointer_load;
    st.state == S_WR && !start_cond && !stop_cond && fall && st.cnt == 4'h8 && st.idx == 2'h0
      |=> st.ptr == $past(st.sh);
  endproperty
  a_pointer_load: assert property (p_pointer_load) else $error("First write byte not in pointer.");
endmodule : thermal_monitor_serial_regs

// ---- tb/smbus_host_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus master model
// ----------------------------------------------------------------
module smbus_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  // Idle bus: clock high, data released to its pull-up.
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // Four system clocks per step (clock high one step, low two), so the slave sees two or more samples of each level.
  task automatic half;
    repeat (4) @(negedge i_clk);
  endtask : half

  // Data moves only with the clock low and is sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    o_sda_pull = !b;
    half();
    o_scl = 1'b1;
    half();
    s = i_sda;
    o_scl = 1'b0;
    half();
  endtask : bit_io

  // Start works from idle and as a repeated start.
  task automatic start;
    o_sda_pull = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_pull = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask : start

  // Stop: data low, clock high, then data released while the clock is high.
  task automatic stop;
    o_sda_pull = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_pull = 1'b0;
    half();
  endtask : stop

  // Eight bits most significant first, then the slave's acknowledge.
  task automatic byte_out(input logic [7:0] b, output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ok = !s;
  endtask : byte_out

  // One byte in, closed by a no-acknowledge since reads carry one byte.
  task automatic byte_in(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(1'b1, s);
  endtask : byte_in

  // Write of one or two bytes after the address.
  task automatic wr(input logic [6:0] a, input int n, input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic k;
    start();
    byte_out({a, 1'b0}, ok);
    if (ok) begin
      byte_out(p, k);
      if (n == 2) begin
        byte_out(d, k);
      end
    end
    stop();
  endtask : wr

  // Read of exactly one byte; a refused address leaves the value all ones.
  task automatic rd(input logic [6:0] a, output logic [7:0] v, output logic ok);
    start();
    byte_out({a, 1'b1}, ok);
    v = 8'hFF;
    if (ok) begin
      byte_in(v);
    end
    stop();
  endtask : rd
endmodule : smbus_host_model

// ---- tb/thermal_monitor_serial_regs_tb.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module thermal_monitor_serial_regs_tb;
  import thermal_pkg::*;
  // Short base period keeps a rate-7 conversion at twenty clocks.
  localparam int BASE = 20;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic scl, pull, sda, oe, alarm_oe, conv_start, k, sdo, alarm_pin;
  logic conv_done = 1'b0;
  logic sleep_n = 1'b0;
  logic [1:0] strap1 = STRAP_OPEN;
  logic [1:0] strap2 = STRAP_HIGH;
  logic [7:0] v;
  logic [6:0] own;
  meas_s meas;
  int n_errors = 0;
  int comparisons = 0;
  int n_conv = 0;
  int c0;

  // Open-drain data wire with a pull-up.
  assign sda = !(pull | (oe & !sdo));

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  thermal_monitor_serial_regs #(.BASE_CYCLES(BASE)) u_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_serial_data_line(sda),
    .o_serial_data_line(sdo), .o_serial_data_line_oe(oe), .i_sleep_pin_n(sleep_n),
    .i_addr_strap_first(strap1), .i_addr_strap_second(strap2), .o_alarm_n(alarm_pin),
    .o_alarm_n_oe(alarm_oe), .o_conv_start(conv_start), .i_conv_done(conv_done), .i_meas(meas));
  smbus_host_model u_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  // Clock at 100 MHz.
  initial begin
    forever #5 i_clk = !i_clk;
  end

  // Converter stand-in answers one cycle after each start and counts starts.
  always @(negedge i_clk) begin
    conv_done <= conv_start;
    if (conv_start === 1'b1) begin
      n_conv++;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Pointer is loaded with the given address, then one data byte is written.
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    u_host.wr(own, 2, p, d, k);
    `CHK(k, 1'b1);
  endtask : reg_wr

  // Pointer is loaded with a read address, then one byte is read.
  task automatic chk_reg(input logic [7:0] p, input logic [7:0] e);
    u_host.wr(own, 1, p, 8'h00, k);
    u_host.rd(own, v, k);
    `CHK(v, e);
  endtask : chk_reg

  // Count converter starts over a window of n clocks.
  task automatic window(input int n);
    c0 = n_conv;
    repeat (n) @(negedge i_clk);
    c0 = n_conv - c0;
  endtask : window

  task automatic one_shot;
    u_host.wr(own, 1, WR_SHOT, 8'h00, k);
    repeat (20) @(negedge i_clk);
  endtask : one_shot

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Power-on values with the sleep pin holding the converter off.
  task automatic t_reset;
    logic [7:0] tbl [8][2];
    tbl = '{'{RD_LOCAL, 8'h80}, '{RD_REMOTE, 8'h80}, '{RD_CTRL, 8'h00}, '{RD_RATE, 8'h02},
            '{RD_LHI, 8'h7F}, '{RD_LLO, 8'hC9}, '{RD_RHI, 8'h7F}, '{RD_RLO, 8'hC9}};
    for (int i = 0; i < 8; i++) begin
      chk_reg(tbl[i][0], tbl[i][1]);
    end
    reg_wr(WR_CTRL, 8'h40);
    one_shot();
    `CHK(n_conv, 0);
    reg_wr(WR_CTRL, 8'h00);
  endtask : t_reset

  // Address match, refusal, late strap change and read-only writes.
  task automatic t_addr;
    u_host.rd(own ^ 7'h01, v, k);
    `CHK(k, 1'b0);
    strap1 = STRAP_LOW;
    strap2 = STRAP_LOW;
    u_host.rd(7'h18, v, k);
    `CHK(k, 1'b0);
    reg_wr(RD_LOCAL, 8'h55);
    chk_reg(RD_LOCAL, 8'h80);
  endtask : t_addr

  // Write and read back, repeated read on the retained pointer.
  task automatic t_regs;
    reg_wr(WR_RLO, 8'h05);
    chk_reg(RD_RLO, 8'h05);
    reg_wr(WR_LHI, 8'h40);
    chk_reg(RD_LHI, 8'h40);
    u_host.rd(own, v, k);
    `CHK(v, 8'h40);
    reg_wr(WR_RLO, 8'hC9);
    reg_wr(WR_CTRL, 8'hFF);
    chk_reg(RD_CTRL, 8'hC0);
    reg_wr(WR_CTRL, 8'h00);
  endtask : t_regs

  // Rate codes, standby freeze and one-shot conversions.
  task automatic t_conv;
    meas.local_temp = 8'h19;
    sleep_n = 1'b1;
    reg_wr(WR_RATE, 8'h07);
    chk_reg(RD_RATE, 8'h07);
    window(400);
    `CHK(c0 >= 19 && c0 <= 21, 1'b1);
    reg_wr(WR_RATE, 8'h06);
    window(400);
    `CHK(c0 >= 9 && c0 <= 11, 1'b1);
    reg_wr(WR_CTRL, 8'h40);
    meas.local_temp = 8'h33;
    window(400);
    `CHK(c0, 0);
    chk_reg(RD_LOCAL, 8'h19);
    c0 = n_conv;
    one_shot();
    repeat (400) @(negedge i_clk);
    `CHK(n_conv - c0, 1);
    chk_reg(RD_LOCAL, 8'h33);
    c0 = n_conv;
    reg_wr(WR_SHOT, 8'h5A);
    repeat (20) @(negedge i_clk);
    `CHK(n_conv - c0, 1);
    chk_reg(RD_CTRL, 8'h40);
  endtask : t_conv

  // Strict compare, latch, mask, status read and alert response.
  task automatic t_alarm;
    // Power-on values sit below the low limits, so both low flags have been up since reset.
    chk_reg(RD_STATUS, 8'h28);
    u_host.rd(ALERT_RESP_ADDR, v, k);
    `CHK(v, {own, 1'b0});
    `CHK(alarm_oe, 1'b0);
    meas.local_temp = 8'h40;
    one_shot();
    `CHK(alarm_oe, 1'b0);
    meas.local_temp = 8'h41;
    one_shot();
    `CHK(alarm_oe, 1'b1);
    `CHK(alarm_pin, 1'b0);
    reg_wr(WR_CTRL, 8'hC0);
    `CHK(alarm_oe, 1'b0);
    reg_wr(WR_CTRL, 8'h40);
    meas.local_temp = 8'h19;
    one_shot();
    `CHK(alarm_oe, 1'b1);
    u_host.rd(ALERT_RESP_ADDR, v, k);
    `CHK(v, {own, 1'b0});
    `CHK(alarm_oe, 1'b1);
    chk_reg(RD_STATUS, 8'h40);
    `CHK(alarm_oe, 1'b1);
    chk_reg(RD_STATUS, 8'h00);
    u_host.rd(ALERT_RESP_ADDR, v, k);
    `CHK(v, {own, 1'b0});
    repeat (4) @(negedge i_clk);
    `CHK(alarm_oe, 1'b0);
  endtask : t_alarm

  // A second reset takes the new strap levels and restores power-on values.
  task automatic t_restrap;
    sleep_n = 1'b0;
    strap1 = STRAP_HIGH;
    strap2 = STRAP_LOW;
    i_srst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clk);
    own = 7'h4C;
    u_host.rd(own, v, k);
    `CHK(k, 1'b1);
    `CHK(v, 8'h80);
  endtask : t_restrap

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Expected own address follows the strap levels held at release.
  initial begin
    own = {ADDR_HI_OPEN, ADDR_LO_BASE_OPEN + 3'h2};
    meas = '0;
    meas.local_temp = 8'h19;
    meas.remote_temp = 8'h19;
    repeat (12) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clk);
    t_reset();
    t_addr();
    t_regs();
    t_conv();
    t_alarm();
    t_restrap();
    close_out();
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (95000) @(posedge i_clk);
    n_errors++;
    close_out();
  end
endmodule : thermal_monitor_serial_regs_tb
